// File: rtl/adc_link_pkg.sv
// Package holding the constants shared by both ends of the converter link.
// Assumes a 20 MHz system clock on each end.
package adc_link_pkg;
	localparam int CLK_MHZ          = 20;
	localparam int RESULT_W         = 10;
	localparam int ADDR_W           = 4;
	localparam int CNT_W            = 5;
	// Shift-clock edge numbers that mark the sequence.
	localparam logic [4:0] ADDR_EDGES    = 5'h04;
	localparam logic [4:0] SAMPLE_START  = 5'h04;
	localparam logic [4:0] SAMPLE_HOLD   = 5'h0a;
	localparam logic [4:0] XFER_MIN      = 5'h0b;
	localparam logic [4:0] XFER_MAX      = 5'h10;
	// Timing figures in nanoseconds.
	localparam int SETUP_NS         = 1425;
	localparam int DEADLINE_NS      = 9500;
	localparam int PHASE_MIN_NS     = 190;
	localparam int CLK_PERIOD_NS    = 1000 / CLK_MHZ;
	// Least times round up, longest times round down.
	localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEADLINE_CYC  = DEADLINE_NS / CLK_PERIOD_NS;
	localparam int PHASE_CYC     =
		(PHASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Internal converter clock: falling edge every SYS_DIV cycles.
	localparam int SYS_DIV          = 4;
	localparam int CONV_CYC         = 88;
	localparam logic [9:0] FULL_SCALE = 10'h3ff;
	localparam logic [9:0] ZERO_SCALE = 10'h000;
	localparam logic [3:0] ADDR_RESET = 4'h0;
endpackage : adc_link_pkg

// File: rtl/adc_link_if.sv
// Interface carrying the four wires between host and converter.
// Assumes the bench resolves the data line from its output enable.
`timescale 1ns/1ns
interface adc_link_if;
	logic sel_n;      // Active-low select from host.
	logic sclk;       // Shift clock from host.
	logic addr;       // Channel address bit from host.
	logic dout;       // Result bit driven by converter.
	logic dout_oe_n;  // Low while the converter drives dout.
	modport conv (input sel_n, input sclk, input addr,
		output dout, output dout_oe_n);
	modport host (output sel_n, output sclk, output addr,
		input dout, input dout_oe_n);
endinterface : adc_link_if

// File: rtl/adc_conv_end.sv
// Converter end: select sequencing, address capture, sampling, result.
// Assumes the link pins come from the host on another clock; all pins are
// synchronised here before use. The analog value arrives as a code input.
//
// What this block does
// - Select falling starts every new sequence.
// - Select falling mid-cycle aborts to setup wait.
// - Abort keeps the last completed result.
// - Host avoids select near conversion end.
// - Result saturates at full scale and zero.
// - Controls ignored until both setup and two ticks pass.
// - Host waits setup before first address bit.
// - Host rises shift clock soon after tenth.
// - Host shift clock phases at least minimum.
// - Four address bits captured MSB first.
// - Sample from fourth fall, hold at tenth.
// - Late eleventh edge loses sync until reselect.
// - Select rising floats the result output.
`timescale 1ns/1ns
module adc_conv_end
	import adc_link_pkg::*;
(
	input  wire logic                             CLK,
	input  wire logic                             RESETN,
	adc_link_if.conv                              LINK,
	input  wire logic [adc_link_pkg::RESULT_W-1:0] ANALOG_CODE,
	input  wire logic                             ABOVE_REF,
	input  wire logic                             BELOW_REF,
	output logic      [adc_link_pkg::ADDR_W-1:0]   CHANNEL,
	output logic                                  SAMPLING,
	output logic                                  BUSY,
	output logic                                  SYNC_LOST
);
	import adc_link_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_WAIT  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_CONV  = 3'b011,
		ST_LOST  = 3'b100
	} cstate_t;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers for the three host pins.
	logic [2:0] meta;
	logic [2:0] sync;
	logic [2:0] prev;
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			// Idle pin levels: select high, shift clock and address low.
			// Matching them avoids a false shift-clock fall after reset.
			meta <= 3'h4;
			sync <= 3'h4;
			prev <= 3'h4;
		end else begin
			meta <= {LINK.sel_n, LINK.sclk, LINK.addr};
			sync <= meta;
			prev <= sync;
		end
	end

	logic sel_fall, sel_rise, sck_rise, sck_fall;
	assign sel_fall = prev[2] & ~sync[2];
	assign sel_rise = ~prev[2] & sync[2];
	assign sck_rise = ~prev[1] & sync[1];
	assign sck_fall = prev[1] & ~sync[1];

	////////////////////////////////////////////////////////////////////////
	// Sequence state, counters, shift registers and result.
	cstate_t              state, next_state;
	logic [CNT_W-1:0]     rise_cnt, next_rise_cnt;
	logic [CNT_W-1:0]     fall_cnt, next_fall_cnt;
	logic [15:0]          timer, next_timer;
	logic [2:0]           ticks, next_ticks;
	logic [ADDR_W-1:0]    addr_sh, next_addr_sh;
	logic [ADDR_W-1:0]    channel, next_channel;
	logic [RESULT_W-1:0]  result, next_result;
	logic [RESULT_W-1:0]  out_sh, next_out_sh;
	logic [RESULT_W-1:0]  held, next_held;
	logic                 dout, next_dout;
	logic                 oe_n, next_oe_n;
	logic                 sampling, next_sampling;
	logic                 lost, next_lost;
	logic                 busy, next_busy;

	// Saturating result code for the current sample.
	function automatic logic [RESULT_W-1:0] saturate(
		input logic [RESULT_W-1:0] code,
		input logic                hi,
		input logic                lo);
		if (hi)
			return FULL_SCALE;
		else if (lo)
			return ZERO_SCALE;
		else
			return code;
	endfunction : saturate

	// Next-state logic of the whole sequence.
	always_comb begin
		next_state    = state;
		next_rise_cnt = rise_cnt;
		next_fall_cnt = fall_cnt;
		next_timer    = timer;
		next_ticks    = ticks;
		next_addr_sh  = addr_sh;
		next_channel  = channel;
		next_result   = result;
		next_out_sh   = out_sh;
		next_held     = held;
		next_dout     = dout;
		next_oe_n     = oe_n;
		next_sampling = sampling;
		next_lost     = lost;
		if (sel_fall) begin
			// restart on select
			// A fall always restarts; result is left alone so an abort keeps it.
			next_state    = ST_WAIT;
			next_rise_cnt = '0;
			next_fall_cnt = '0;
			next_timer    = '0;
			next_ticks    = '0;
			next_sampling = 1'b0;
			next_lost     = 1'b0;
			next_oe_n     = 1'b0;
			next_out_sh   = result;
			next_dout     = result[RESULT_W-1];
		end else if (sel_rise) begin
			next_state    = ST_IDLE;
			next_oe_n     = 1'b1;
			next_sampling = 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					next_oe_n = 1'b1;
				end
				ST_WAIT: begin
					next_timer = timer + 16'h0001;
					if (timer[1:0] == 2'h3 && ticks != 3'h2)
						next_ticks = ticks + 3'h1;
					if (timer >= 16'(SETUP_CYC) && ticks == 3'h2)
						next_state = ST_SHIFT;
				end
				ST_SHIFT: begin
					if (sck_rise) begin
						next_rise_cnt = rise_cnt + 5'h01;
						if (rise_cnt < ADDR_EDGES)
							next_addr_sh = {addr_sh[ADDR_W-2:0], sync[0]};
					end
					if (sck_fall) begin
						next_fall_cnt = fall_cnt + 5'h01;
						if (fall_cnt < 5'(RESULT_W - 1)) begin
							next_out_sh = {out_sh[RESULT_W-2:0], 1'b0};
							next_dout   = out_sh[RESULT_W-2];
						end else begin
							next_dout = 1'b0;
						end
						if (fall_cnt + 5'h01 == SAMPLE_START) begin
							next_sampling = 1'b1;
							next_channel  = addr_sh;
						end
						if (fall_cnt + 5'h01 == SAMPLE_HOLD) begin
							next_sampling = 1'b0;
							next_held     = saturate(ANALOG_CODE, ABOVE_REF,
								BELOW_REF);
							next_timer    = '0;
							next_state    = ST_CONV;
						end
					end
				end
				ST_CONV: begin
					next_timer = timer + 16'h0001;
					if (sck_rise) begin
						next_rise_cnt = rise_cnt + 5'h01;
					end
					if (timer == 16'(DEADLINE_CYC) && rise_cnt < XFER_MIN) begin
						next_lost  = 1'b1;
						next_state = ST_LOST;
					end else if (timer == 16'(CONV_CYC)) begin
						next_result = held;
					end
				end
				ST_LOST: begin
					next_lost = 1'b1;
				end
				default: next_state = ST_IDLE;
			endcase
		end
		// Busy follows the convert state so the output is a register.
		next_busy = (next_state == ST_CONV);
	end

	// State registers; only reset constants are loaded asynchronously.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state    <= ST_IDLE;
			rise_cnt <= '0;
			fall_cnt <= '0;
			timer    <= '0;
			ticks    <= '0;
			addr_sh  <= ADDR_RESET;
			channel  <= ADDR_RESET;
			result   <= ZERO_SCALE;
			out_sh   <= ZERO_SCALE;
			held     <= ZERO_SCALE;
			dout     <= 1'b0;
			oe_n     <= 1'b1;
			sampling <= 1'b0;
			lost     <= 1'b0;
			busy     <= 1'b0;
		end else begin
			state    <= next_state;
			rise_cnt <= next_rise_cnt;
			fall_cnt <= next_fall_cnt;
			timer    <= next_timer;
			ticks    <= next_ticks;
			addr_sh  <= next_addr_sh;
			channel  <= next_channel;
			result   <= next_result;
			out_sh   <= next_out_sh;
			held     <= next_held;
			dout     <= next_dout;
			oe_n     <= next_oe_n;
			sampling <= next_sampling;
			lost     <= next_lost;
			busy     <= next_busy;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs come straight from the registers above.
	assign LINK.dout      = dout;
	assign LINK.dout_oe_n = oe_n;
	assign CHANNEL        = channel;
	assign SAMPLING       = sampling;
	assign BUSY           = busy;
	assign SYNC_LOST      = lost;
endmodule : adc_conv_end

// File: rtl/adc_host_end.sv
// Host end: drives select, shift clock and address, collects the result.
// Assumes the converter end sits on the same interface; dout is
// synchronised before use.
`timescale 1ns/1ns
module adc_host_end
	import adc_link_pkg::*;
#(
	parameter int XFER_LEN = 16
) (
	input  wire logic                             CLK,
	input  wire logic                             RESETN,
	adc_link_if.host                              LINK,
	input  wire logic                             START,
	input  wire logic [adc_link_pkg::ADDR_W-1:0]   CHANNEL,
	output logic      [adc_link_pkg::RESULT_W-1:0] RESULT,
	output logic                                  DONE
);
	import adc_link_pkg::*;

	// Refuse transfer lengths that the slow-mode sequence cannot serve.
	if (XFER_LEN < 11 || XFER_LEN > 16) begin : g_len_check
		$error("XFER_LEN must lie between 11 and 16");
	end

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_SETUP = 2'b01,
		H_SHIFT = 2'b10,
		H_END   = 2'b11
	} hstate_t;

	// Shift clock phase length: rounded up and doubled for margin.
	localparam int HALF_CYC = PHASE_CYC * 2;

	////////////////////////////////////////////////////////////////////////
	// Synchroniser for the returned data.
	logic d_meta, d_sync;
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			d_meta <= 1'b0;
			d_sync <= 1'b0;
		end else begin
			d_meta <= LINK.dout;
			d_sync <= d_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	hstate_t              state, next_state;
	logic [15:0]          timer, next_timer;
	logic [4:0]           edges, next_edges;
	logic                 sel_n, next_sel_n;
	logic                 sclk, next_sclk;
	logic                 addr, next_addr;
	logic [ADDR_W-1:0]    chan, next_chan;
	logic [RESULT_W-1:0]  rx, next_rx;
	logic [RESULT_W-1:0]  result, next_result;
	logic                 done, next_done;

	// Host sequence; the phase timer paces every clock edge.
	always_comb begin
		next_state  = state;
		next_timer  = timer + 16'h0001;
		next_edges  = edges;
		next_sel_n  = sel_n;
		next_sclk   = sclk;
		next_addr   = addr;
		next_chan   = chan;
		next_rx     = rx;
		next_result = result;
		next_done   = 1'b0;
		case (state)
			H_IDLE: begin
				next_timer = '0;
				if (START) begin
					next_sel_n = 1'b0;
					next_chan  = CHANNEL;
					next_addr  = CHANNEL[ADDR_W-1];
					next_edges = '0;
					next_state = H_SETUP;
				end
			end
			H_SETUP: begin
				if (timer >= 16'(SETUP_CYC + 4 * SYS_DIV)) begin
					next_timer = '0;
					next_state = H_SHIFT;
				end
			end
			H_SHIFT: begin
				if (timer >= 16'(HALF_CYC)) begin
					next_timer = '0;
					next_sclk  = ~sclk;
					if (!sclk) begin
						// Only the first ten rising edges carry result bits;
						// later ones would push the result out of the register.
						if (edges < 5'(RESULT_W))
							next_rx = {rx[RESULT_W-2:0], d_sync};
						next_chan  = {chan[ADDR_W-2:0], 1'b0};
					end else begin
						next_edges = edges + 5'h01;
						next_addr  = chan[ADDR_W-1];
						if (edges + 5'h01 == 5'(XFER_LEN))
							next_state = H_END;
					end
				end
			end
			H_END: begin
				next_sel_n  = 1'b1;
				next_result = rx;
				next_done   = 1'b1;
				next_state  = H_IDLE;
			end
			default: next_state = H_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state  <= H_IDLE;
			timer  <= '0;
			edges  <= '0;
			sel_n  <= 1'b1;
			sclk   <= 1'b0;
			addr   <= 1'b0;
			chan   <= ADDR_RESET;
			rx     <= ZERO_SCALE;
			result <= ZERO_SCALE;
			done   <= 1'b0;
		end else begin
			state  <= next_state;
			timer  <= next_timer;
			edges  <= next_edges;
			sel_n  <= next_sel_n;
			sclk   <= next_sclk;
			addr   <= next_addr;
			chan   <= next_chan;
			rx     <= next_rx;
			result <= next_result;
			done   <= next_done;
		end
	end

	assign LINK.sel_n = sel_n;
	assign LINK.sclk  = sclk;
	assign LINK.addr  = addr;
	assign RESULT     = result;
	assign DONE       = done;
endmodule : adc_host_end

// File: tb/adc_link_asserts.sv
// Checker watching the four link wires between host and converter ends.
// Assumes it is instantiated beside the link interface in the bench top.
`timescale 1ns/1ns
module adc_link_asserts
	import adc_link_pkg::*;
#(
	parameter int XFER_LEN = 16
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic addr,
	input wire logic dout,
	input wire logic dout_oe_n
);
	import adc_link_pkg::*;
	localparam int DEADLINE = 190;
	logic       sclk_q;
	logic [7:0] since_sel;
	logic [7:0] next_since_sel;
	logic [4:0] rises;
	logic [4:0] next_rises;
	logic [4:0] falls;
	logic [4:0] next_falls;

	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);

	////////////////////////////////////////////////////////////////////////
	// Counters of select-low cycles and of clock edges, cleared by select.
	always_comb begin
		next_since_sel = since_sel + {7'h00, since_sel != 8'hff};
		next_rises = rises + {4'h0, sclk & ~sclk_q};
		next_falls = falls + {4'h0, ~sclk & sclk_q};
		if (sel_n) begin
			next_since_sel = 8'h00;
			next_rises = 5'h00;
			next_falls = 5'h00;
		end
	end

	// Register the counters; reset clears them all.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sclk_q <= 1'b0;
			since_sel <= 8'h00;
			rises <= 5'h00;
			falls <= 5'h00;
		end else begin
			sclk_q <= sclk;
			since_sel <= next_since_sel;
			rises <= next_rises;
			falls <= next_falls;
		end
	end

	////////////////////////////////////////////////////////////////////////
	sequence sel_start_s;
		$fell(sel_n);
	endsequence
	sequence drive_soon_s;
		##[1:6] !dout_oe_n;
	endsequence
	sequence tenth_fall_s;
		$fell(sclk) && falls == 5'h09 && !sel_n;
	endsequence

	sel_drive_a: assert property (sel_start_s |-> drive_soon_s)
		else $error("result line not driven after select fell");
	sel_float_a: assert property ($rose(sel_n) |-> ##[1:6] dout_oe_n)
		else $error("result line not released after select rose");
	setup_wait_a: assert property ($rose(sclk) |-> since_sel >= 8'(SETUP_CYC))
		else $error("shift clock rose before select setup time");
	high_phase_a: assert property ($rose(sclk) |-> sclk [*4])
		else $error("shift clock high phase too short");
	low_phase_a: assert property ($fell(sclk) |-> !sclk [*4])
		else $error("shift clock low phase too short");
	tenth_deadline_a: assert property (tenth_fall_s |-> ##[1:DEADLINE] $rose(sclk))
		else $error("no shift clock rise soon after tenth fall");
	addr_setup_a: assert property ($rose(sclk) |-> addr == $past(addr, 2))
		else $error("address bit moved just before shift clock rose");
	frame_len_a: assert property ($rose(sel_n) |-> rises == 5'(XFER_LEN))
		else $error("transfer length differs from configured length");
endmodule : adc_link_asserts

// File: tb/serial_adc_select_sequencer_tb.sv
// Bench joining host end and converter end across the link interface.
// Assumes both ends share one clock; the host may be reset alone to abort.
`timescale 1ns/1ns
module serial_adc_select_sequencer_tb;
	import adc_link_pkg::*;
	logic                clk;
	logic                rst_n;
	logic                host_rst_n;
	logic                start;
	logic                above;
	logic                below;
	logic                done;
	logic                sync_lost;
	logic                sampling;
	logic                busy;
	logic                exp_win;
	int                  frame_rise;
	logic                have_prev;
	logic [ADDR_W-1:0]   ch_in;
	logic [ADDR_W-1:0]   ch_out;
	logic [RESULT_W-1:0] code;
	logic [RESULT_W-1:0] result;
	logic [RESULT_W-1:0] prev;
	logic [13:0]         notes[$];
	logic [13:0]         note;
	int                  num_errors;
	int                  checked;
	int                  falls;
	wire                 host_rn = rst_n & host_rst_n;

	adc_link_if link();
	adc_host_end #(.XFER_LEN(16)) adc_host_end_inst (.CLK(clk),
		.RESETN(host_rn), .LINK(link.host), .START(start), .CHANNEL(ch_in),
		.RESULT(result), .DONE(done));
	adc_conv_end adc_conv_end_inst (.CLK(clk), .RESETN(rst_n),
		.LINK(link.conv), .ANALOG_CODE(code), .ABOVE_REF(above),
		.BELOW_REF(below), .CHANNEL(ch_out), .SAMPLING(sampling), .BUSY(busy),
		.SYNC_LOST(sync_lost));
	adc_link_asserts #(.XFER_LEN(16)) adc_link_asserts_inst (.CLK(clk),
		.RESETN(host_rn), .sel_n(link.sel_n), .sclk(link.sclk),
		.addr(link.addr), .dout(link.dout), .dout_oe_n(link.dout_oe_n));

	////////////////////////////////////////////////////////////////////////
	// Compare one value and count it.
	task automatic compare(string what, logic [13:0] exp, logic [13:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : compare

	// Print the counts and the verdict, then stop.
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	// Run one transfer; an abort resets the host after the tenth fall.
	task automatic frame(logic [3:0] ch, logic [9:0] c, logic hi, logic lo,
		bit abort);
		int n;
		@(negedge clk);
		ch_in = ch;
		code = c;
		above = hi;
		below = lo;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		if (abort) begin
			n = falls + 10;
			wait (falls == n);
			repeat (5) @(negedge clk);
			host_rst_n = 1'b0;
			repeat (3) @(negedge clk);
			host_rst_n = 1'b1;
			return;
		end
		if (have_prev) begin
			notes.push_back({ch, prev});
		end
		prev = hi ? FULL_SCALE : (lo ? ZERO_SCALE : c);
		have_prev = 1'b1;
		n = 0;
		while (done !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		// A transfer that never finishes counts as a mismatch.
		if (n >= 3000) begin
			num_errors++;
			$display("CHECK FAILED done expected 1 seen 0");
		end
		repeat (4) @(negedge clk);
	endtask : frame

	////////////////////////////////////////////////////////////////////////
	// Free-running system clock.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Count shift clock falls to place the abort.
	always @(negedge link.sclk) begin
		falls++;
	end

	// Rising shift edges are counted afresh in every select-low frame.
	always @(posedge link.sel_n) begin
		frame_rise = 0;
	end

	// sample window and convert state at each rising shift edge.
	always @(posedge link.sclk) begin
		frame_rise++;
		exp_win = (frame_rise > 4) && (frame_rise < 11);
		compare("sampling", 14'(exp_win), 14'(sampling));
		compare("busy", 14'(frame_rise > 10), 14'(busy));
	end

	// Take the oldest note whenever a result is delivered.
	always @(posedge clk) begin
		if (done === 1'b1 && notes.size() > 0) begin
			note = notes.pop_front();
			compare("result", {4'h0, note[9:0]}, {4'h0, result});
			compare("channel", {10'h000, note[13:10]}, {10'h000, ch_out});
			compare("sync", 14'h0000, {13'h0000, sync_lost});
		end
	end

	// Main sequence.
	initial begin
		rst_n = 1'b0;
		host_rst_n = 1'b1;
		start = 1'b0;
		ch_in = 4'h0;
		code = 10'h000;
		above = 1'b0;
		below = 1'b0;
		have_prev = 1'b0;
		prev = 10'h000;
		num_errors = 0;
		checked = 0;
		falls = 0;
		frame_rise = 0;
		void'($urandom(32'hfb620af7));
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		frame(4'h0, 10'h155, 1'b1, 1'b0, 1'b0);
		frame(4'h5, 10'h2aa, 1'b0, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			frame(4'($urandom), 10'($urandom), 1'b0, 1'b0, 1'b0);
		end
		$display("test saturation and address finished");
		frame(4'h3, 10'h0f0, 1'b0, 1'b0, 1'b1);
		frame(4'ha, 10'h1c3, 1'b0, 1'b0, 1'b0);
		frame(4'hf, 10'h001, 1'b0, 1'b0, 1'b0);
		$display("test abort finished");
		// Every noted result must have been delivered.
		compare("notes left", 14'h0000, 14'(notes.size()));
		end_sim();
	end

	// Watchdog against a hung handshake.
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("watchdog expired");
		end_sim();
	end
endmodule : serial_adc_select_sequencer_tb
